// [shared/xprc_pkg.sv]
// shared constants, field layouts and state codes of the transceiver pll/reset/power control block
// assumes a single 200 MHz clock domain and an AXI4-Lite register port with 32-bit data
package xprc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned NUM_CH        = 4;
    localparam int unsigned SEL_W         = 3;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;

    // register offsets, byte addresses
    localparam logic [ADDR_W-1:0] CTRL_OFF   = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] EVENT_OFF  = 8'h08;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // shortest legal pulse on the digital/analog reset pins, in parallel clock cycles
    localparam logic [1:0] MIN_PULSE_CYC = 2'h2;

    // reference input indices when latency mode runs without feedback
    localparam logic [SEL_W-1:0] TX_REF_IDX = 3'h0;
    localparam logic [SEL_W-1:0] RX_REF_IDX = 3'h1;

    typedef struct packed {
        logic bonded;
        logic pipeMode;
        logic pfdFeedback;
        logic detLatency;
        logic swRxDigRst;
        logic swRxAnaRst;
        logic swTxDigRst;
        logic swPowerDown;
        logic swPllReset;
    } xprc_ctrl_t;

    typedef struct packed {
        logic rxCodingRst;
        logic rxMediumRst;
        logic txCodingRst;
        logic powerDown;
        logic pllHold;
        logic pllLock;
    } xprc_status_t;

    typedef struct packed {
        logic earlyRxRelease;
        logic earlyTxRelease;
        logic shortRxDig;
        logic shortRxAna;
        logic shortTxDig;
    } xprc_event_t;

    localparam xprc_ctrl_t  CTRL_RST  = 9'h000;
    localparam xprc_event_t EVENT_RST = 5'h00;

    typedef enum logic [1:0] {
        LK_HOLD    = 2'h0,
        LK_ACQUIRE = 2'h1,
        LK_LOCKED  = 2'h3,
        LK_DOWN    = 2'h2
    } xprc_lock_t;

endpackage : xprc_pkg

// [hdl/xprc_ctrl.sv]
// pll reset, lock report, reference routing, power-down and coding reset control with AXI4-Lite registers
// assumes pins synchronous to clk; the analog pll reports raw lock on pllLockRaw
`timescale 1ns/10ps
module xprc_ctrl
(
    input  wire logic                                    clk,
    input  wire logic                                    rst,
    input  wire logic                                    s_axi_awvalid,
    output logic                                         s_axi_awready,
    input  wire logic [xprc_pkg::ADDR_W-1:0]             s_axi_awaddr,
    input  wire logic                                    s_axi_wvalid,
    output logic                                         s_axi_wready,
    input  wire logic [xprc_pkg::DATA_W-1:0]             s_axi_wdata,
    input  wire logic [3:0]                              s_axi_wstrb,
    output logic                                         s_axi_bvalid,
    input  wire logic                                    s_axi_bready,
    output logic [1:0]                                   s_axi_bresp,
    input  wire logic                                    s_axi_arvalid,
    output logic                                         s_axi_arready,
    input  wire logic [xprc_pkg::ADDR_W-1:0]             s_axi_araddr,
    output logic                                         s_axi_rvalid,
    input  wire logic                                    s_axi_rready,
    output logic [xprc_pkg::DATA_W-1:0]                  s_axi_rdata,
    output logic [1:0]                                   s_axi_rresp,
    input  wire logic                                    pllResetIn,
    input  wire logic                                    powerDownIn,
    input  wire logic                                    txDigResetIn,
    input  wire logic                                    rxAnaResetIn,
    input  wire logic                                    rxDigResetIn,
    input  wire logic                                    pllLockRaw,
    output logic                                         pllHold,
    output logic                                         pllLock,
    output logic [xprc_pkg::NUM_CH*xprc_pkg::SEL_W-1:0]  txRefSel,
    output logic [xprc_pkg::NUM_CH*xprc_pkg::SEL_W-1:0]  rxRefSel,
    output logic                                         fabricClkOut,
    output logic                                         pdCodingSublayer,
    output logic                                         pdHighSpeedSerialIf,
    output logic                                         pdClockDataRecovery,
    output logic                                         pdPcie,
    output logic                                         refClkBufEn,
    output logic                                         txCodingSublayerRst,
    output logic                                         rxMediumAttachmentRst,
    output logic                                         rxCodingSublayerRst,
    output logic                                         offsetCalClkSel,
    output logic                                         rxDetectClkSel,
    output logic                                         reconfigClkEn
);

    xprc_pkg::xprc_ctrl_t   ctrl;
    xprc_pkg::xprc_event_t  events;
    xprc_pkg::xprc_event_t  eventSet;
    xprc_pkg::xprc_lock_t   lockState;
    xprc_pkg::xprc_lock_t   next_lockState;
    xprc_pkg::xprc_status_t status;

    logic                            pdEff;
    logic                            holdEff;
    logic                            awHave;
    logic                            wHave;
    logic                            awFire;
    logic                            wFire;
    logic                            arFire;
    logic                            doWrite;
    logic                            next_awHave;
    logic                            next_wHave;
    logic                            next_bvalid;
    logic                            next_rvalid;
    logic [xprc_pkg::ADDR_W-1:0]     wrAddrHeld;
    logic [xprc_pkg::DATA_W-1:0]     wrDataHeld;
    logic [3:0]                      wrStrbHeld;
    logic [xprc_pkg::ADDR_W-1:0]     wrAddr;
    logic [xprc_pkg::DATA_W-1:0]     wrData;
    logic [3:0]                      wrStrb;
    logic [xprc_pkg::DATA_W-1:0]     rdWord;
    logic                            rdHit;
    logic                            wrHit;
    logic [2:0]                      rstPins;
    logic [2:0]                      rstPinsPrev;
    logic [1:0]                      pulseCnt [3];
    logic [2:0]                      shortPulse;
    xprc_pkg::xprc_ctrl_t            ctrlWrite;

    // pins and software bits combine; power-down dominates the pll hold
    assign pdEff   = powerDownIn | ctrl.swPowerDown;
    assign holdEff = pllResetIn | ctrl.swPllReset;

    // ---------------- AXI4-Lite write path ----------------
    assign awFire  = s_axi_awvalid & s_axi_awready;
    assign wFire   = s_axi_wvalid & s_axi_wready;
    assign doWrite = (awHave | awFire) & (wHave | wFire);
    assign wrAddr  = awFire ? s_axi_awaddr : wrAddrHeld;
    assign wrData  = wFire ? s_axi_wdata : wrDataHeld;
    assign wrStrb  = wFire ? s_axi_wstrb : wrStrbHeld;
    assign wrHit   = (wrAddr == xprc_pkg::CTRL_OFF) || (wrAddr == xprc_pkg::STATUS_OFF)
                     || (wrAddr == xprc_pkg::EVENT_OFF);

    assign next_awHave = (awHave | awFire) & ~doWrite;
    assign next_wHave  = (wHave | wFire) & ~doWrite;
    assign next_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            awHave        <= 1'b0;
            wHave         <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= xprc_pkg::RESP_OKAY;
            wrAddrHeld    <= '0;
            wrDataHeld    <= '0;
            wrStrbHeld    <= '0;
        end
        else
        begin
            awHave        <= next_awHave;
            wHave         <= next_wHave;
            // no new address or data while a response is still pending
            s_axi_awready <= ~next_awHave & ~next_bvalid;
            s_axi_wready  <= ~next_wHave & ~next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (doWrite)
            begin
                s_axi_bresp <= wrHit ? xprc_pkg::RESP_OKAY : xprc_pkg::RESP_SLVERR;
            end
            if (awFire)
            begin
                wrAddrHeld <= s_axi_awaddr;
            end
            if (wFire)
            begin
                wrDataHeld <= s_axi_wdata;
                wrStrbHeld <= s_axi_wstrb;
            end
        end
    end

    // byte lanes 0 and 1 carry the nine control bits
    always_comb
    begin
        ctrlWrite = ctrl;
        if (wrStrb[0])
        begin
            ctrlWrite[7:0] = wrData[7:0];
        end
        if (wrStrb[1])
        begin
            ctrlWrite[8] = wrData[8];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= xprc_pkg::CTRL_RST;
        end
        else if (doWrite && wrAddr == xprc_pkg::CTRL_OFF)
        begin
            ctrl <= ctrlWrite;
        end
    end

    // ---------------- AXI4-Lite read path ----------------
    assign arFire      = s_axi_arvalid & s_axi_arready;
    assign next_rvalid = arFire | (s_axi_rvalid & ~s_axi_rready);

    always_comb
    begin
        rdWord = '0;
        rdHit  = 1'b1;
        case (s_axi_araddr)
            xprc_pkg::CTRL_OFF:   rdWord[$bits(ctrl)-1:0]   = ctrl;
            xprc_pkg::STATUS_OFF: rdWord[$bits(status)-1:0] = status;
            xprc_pkg::EVENT_OFF:  rdWord[$bits(events)-1:0] = events;
            default:              rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= xprc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (arFire)
            begin
                s_axi_rdata <= rdWord;
                s_axi_rresp <= rdHit ? xprc_pkg::RESP_OKAY : xprc_pkg::RESP_SLVERR;
            end
        end
    end

    // ---------------- pll hold and lock tracking ----------------
    always_comb
    begin
        next_lockState = lockState;
        case (lockState)
            xprc_pkg::LK_HOLD:    next_lockState = xprc_pkg::LK_ACQUIRE;
            xprc_pkg::LK_ACQUIRE: if (pllLockRaw) next_lockState = xprc_pkg::LK_LOCKED;
            xprc_pkg::LK_LOCKED:  if (!pllLockRaw) next_lockState = xprc_pkg::LK_ACQUIRE;
            xprc_pkg::LK_DOWN:    next_lockState = xprc_pkg::LK_HOLD;
            default:              next_lockState = xprc_pkg::LK_HOLD;
        endcase
        if (holdEff)
        begin
            next_lockState = xprc_pkg::LK_HOLD;
        end
        if (pdEff)
        begin
            next_lockState = xprc_pkg::LK_DOWN;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lockState <= xprc_pkg::LK_HOLD;
            pllHold   <= 1'b1;
            pllLock   <= 1'b0;
        end
        else
        begin
            lockState <= next_lockState;
            pllHold   <= holdEff | pdEff;
            pllLock   <= (next_lockState == xprc_pkg::LK_LOCKED);
        end
    end

    // ---------------- reference clock routing ----------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txRefSel <= '0;
            rxRefSel <= '0;
        end
        else
        begin
            for (int i = 0; i < xprc_pkg::NUM_CH; i++)
            begin
                if (ctrl.detLatency && ctrl.pfdFeedback)
                begin
                    txRefSel[i*xprc_pkg::SEL_W +: xprc_pkg::SEL_W] <= xprc_pkg::SEL_W'(i);
                    rxRefSel[i*xprc_pkg::SEL_W +: xprc_pkg::SEL_W] <= xprc_pkg::SEL_W'(xprc_pkg::NUM_CH + i);
                end
                else if (ctrl.detLatency)
                begin
                    txRefSel[i*xprc_pkg::SEL_W +: xprc_pkg::SEL_W] <= xprc_pkg::TX_REF_IDX;
                    rxRefSel[i*xprc_pkg::SEL_W +: xprc_pkg::SEL_W] <= xprc_pkg::RX_REF_IDX;
                end
                else
                begin
                    txRefSel[i*xprc_pkg::SEL_W +: xprc_pkg::SEL_W] <= xprc_pkg::TX_REF_IDX;
                    rxRefSel[i*xprc_pkg::SEL_W +: xprc_pkg::SEL_W] <= xprc_pkg::TX_REF_IDX;
                end
            end
        end
    end

    // ---------------- bonded fabric clock ----------------
    // divide-by-two of clk; stops low outside bonded mode so fabric sees no runt edges
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fabricClkOut <= 1'b0;
        end
        else if (ctrl.bonded && !pdEff)
        begin
            fabricClkOut <= ~fabricClkOut;
        end
        else
        begin
            fabricClkOut <= 1'b0;
        end
    end

    // ---------------- power-down and coding resets ----------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pdCodingSublayer      <= 1'b1;
            pdHighSpeedSerialIf   <= 1'b1;
            pdClockDataRecovery   <= 1'b1;
            pdPcie                <= 1'b1;
            refClkBufEn           <= 1'b1;
            txCodingSublayerRst   <= 1'b1;
            rxMediumAttachmentRst <= 1'b1;
            rxCodingSublayerRst   <= 1'b1;
        end
        else
        begin
            pdCodingSublayer      <= pdEff;
            pdHighSpeedSerialIf   <= pdEff;
            pdClockDataRecovery   <= pdEff;
            pdPcie                <= pdEff;
            refClkBufEn           <= 1'b1;
            txCodingSublayerRst   <= txDigResetIn | ctrl.swTxDigRst | pdEff;
            rxMediumAttachmentRst <= rxAnaResetIn | ctrl.swRxAnaRst | pdEff;
            rxCodingSublayerRst   <= rxDigResetIn | ctrl.swRxDigRst | pdEff;
        end
    end

    // ---------------- calibration clock steering ----------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            offsetCalClkSel <= 1'b0;
            rxDetectClkSel  <= 1'b0;
            reconfigClkEn   <= 1'b1;
        end
        else
        begin
            offsetCalClkSel <= ctrl.pipeMode;
            rxDetectClkSel  <= ctrl.pipeMode;
            reconfigClkEn   <= 1'b1;
        end
    end

    // ---------------- reset pin misuse monitor ----------------
    assign rstPins = {rxDigResetIn, rxAnaResetIn, txDigResetIn};

    for (genvar g = 0; g < 3; g++)
    begin : gPulse
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                pulseCnt[g] <= '0;
            end
            else if (!rstPins[g])
            begin
                pulseCnt[g] <= '0;
            end
            else if (pulseCnt[g] != xprc_pkg::MIN_PULSE_CYC)
            begin
                pulseCnt[g] <= pulseCnt[g] + 2'h1;
            end
        end
        assign shortPulse[g] = rstPinsPrev[g] & ~rstPins[g] & (pulseCnt[g] < xprc_pkg::MIN_PULSE_CYC);
    end

    always_comb
    begin
        eventSet            = xprc_pkg::EVENT_RST;
        eventSet.shortTxDig = shortPulse[0];
        eventSet.shortRxAna = shortPulse[1];
        eventSet.shortRxDig = shortPulse[2];
        eventSet.earlyTxRelease = rstPinsPrev[0] & ~rstPins[0] & ~pllLock;
        eventSet.earlyRxRelease = rstPinsPrev[2] & ~rstPins[2] & ~pllLock;
    end

    // write-one-to-clear; a new event in the clearing cycle survives
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            events      <= xprc_pkg::EVENT_RST;
            rstPinsPrev <= '0;
        end
        else
        begin
            rstPinsPrev <= rstPins;
            if (doWrite && wrAddr == xprc_pkg::EVENT_OFF && wrStrb[0])
            begin
                events <= (events & ~wrData[$bits(events)-1:0]) | eventSet;
            end
            else
            begin
                events <= events | eventSet;
            end
        end
    end

    always_comb
    begin
        status.pllLock     = pllLock;
        status.pllHold     = pllHold;
        status.powerDown   = pdCodingSublayer;
        status.txCodingRst = txCodingSublayerRst;
        status.rxMediumRst = rxMediumAttachmentRst;
        status.rxCodingRst = rxCodingSublayerRst;
    end

endmodule : xprc_ctrl

// [test/xprc_ctrl_checker.sv]
// port-level checks of the pll/reset/power control block
// assumes bind onto xprc_ctrl, single clk domain, async active-high rst
`timescale 1ns/10ps
module xprc_ctrl_checker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pllResetIn,
    input wire logic powerDownIn,
    input wire logic txDigResetIn,
    input wire logic rxAnaResetIn,
    input wire logic rxDigResetIn,
    input wire logic pllLockRaw,
    input wire logic pllHold,
    input wire logic pllLock,
    input wire logic fabricClkOut,
    input wire logic pdCodingSublayer,
    input wire logic pdHighSpeedSerialIf,
    input wire logic pdClockDataRecovery,
    input wire logic pdPcie,
    input wire logic refClkBufEn,
    input wire logic txCodingSublayerRst,
    input wire logic rxMediumAttachmentRst,
    input wire logic rxCodingSublayerRst,
    input wire logic offsetCalClkSel,
    input wire logic rxDetectClkSel,
    input wire logic reconfigClkEn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_lockable;
        (!pllHold && pllLockRaw) [*3];
    endsequence

    a_pll_held: assert property (pllResetIn |=> pllHold && !pllLock) else $error("pll not held");
    a_lock_reached: assert property (s_lockable |-> pllLock) else $error("lock not reported");
    a_lock_not_held: assert property (pllHold |-> !pllLock) else $error("lock while held");
    a_pd_all_off: assert property (powerDownIn |=> pdCodingSublayer && pdHighSpeedSerialIf
        && pdClockDataRecovery && pdPcie) else $error("power-down incomplete");
    a_refbuf_on: assert property (refClkBufEn) else $error("ref buffer off");
    a_fabric_half: assert property (fabricClkOut |=> !fabricClkOut) else $error("fabric clock stuck");
    a_fabric_pd: assert property (powerDownIn |=> !fabricClkOut) else $error("fabric clock in pd");
    a_tx_coding: assert property (txDigResetIn |=> txCodingSublayerRst) else $error("tx coding free");
    a_rx_medium: assert property (rxAnaResetIn |=> rxMediumAttachmentRst) else $error("rx medium free");
    a_rx_coding: assert property (rxDigResetIn |=> rxCodingSublayerRst) else $error("rx coding free");
    a_clock_select: assert property (reconfigClkEn && offsetCalClkSel == rxDetectClkSel)
        else $error("clock select split");
endmodule : xprc_ctrl_checker

bind xprc_ctrl xprc_ctrl_checker checker_i (.*);

// [test/xprc_fabric_model.sv]
// fabric-side driver of the reset pins plus a simple pll lock model
// assumes the bench calls its tasks; pins change just after rising clk
`timescale 1ns/10ps
module xprc_fabric_model #(parameter int LOCK_DLY = 10)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pllHold,
    input  wire logic pllLock,
    output logic      pllResetIn,
    output logic      powerDownIn,
    output logic      txDigResetIn,
    output logic      rxAnaResetIn,
    output logic      rxDigResetIn,
    output logic      pllLockRaw
);
    logic [2:0] rstPins;
    int         lockCnt;

    assign {rxDigResetIn, rxAnaResetIn, txDigResetIn} = rstPins;

    initial
    begin
        pllResetIn  = 1'b1;
        powerDownIn = 1'b0;
        rstPins     = 3'h7;
    end

    // reference always present, lock some cycles after hold drops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst || pllHold)
        begin
            lockCnt    <= 0;
            pllLockRaw <= 1'b0;
        end
        else if (lockCnt < LOCK_DLY)
            lockCnt <= lockCnt + 1;
        else
            pllLockRaw <= 1'b1;
    end

    // pin 0..2 = tx digital, rx analog, rx digital; 3 = pll reset; 4 = power-down
    task automatic drive(input int pin, input logic v);
        @(posedge clk);
        case (pin)
            0, 1, 2: rstPins[pin] <= v;
            3:       pllResetIn <= v;
            default: powerDownIn <= v;
        endcase
    endtask : drive

    // callers give two cycles or more unless a short-pulse event is intended
    task automatic pulse(input int pin, input int len);
        drive(pin, 1'b1);
        repeat (len) @(posedge clk);
        rstPins[pin] <= 1'b0;
    endtask : pulse

    task automatic bring_up();
        int t;
        drive(3, 1'b0);
        for (t = 0; t < 200 && pllLock !== 1'b1; t++)
            @(posedge clk);
        // all three reset pins go one cycle after lock shows, or after 201 cycles without it
        @(posedge clk);
        rstPins <= 3'h0;
    endtask : bring_up
endmodule : xprc_fabric_model

// [test/xprc_ctrl_test.sv]
// self-checking bench: AXI4-Lite register tasks and fabric-side pin model
// assumes xprc_ctrl, its checker bind and xprc_fabric_model are compiled first
`timescale 1ns/10ps
module xprc_ctrl_test;
    logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        pllResetIn, powerDownIn, txDigResetIn, rxAnaResetIn, rxDigResetIn, pllLockRaw;
    logic        pllHold, pllLock, fabricClkOut, refClkBufEn, reconfigClkEn, fc;
    logic        pdCodingSublayer, pdHighSpeedSerialIf, pdClockDataRecovery, pdPcie;
    logic        txCodingSublayerRst, rxMediumAttachmentRst, rxCodingSublayerRst;
    logic        offsetCalClkSel, rxDetectClkSel;
    logic [11:0] txRefSel, rxRefSel;
    int          errors, n_tests, cyc, i;

    xprc_ctrl dut (.*);
    xprc_fabric_model model (.*);

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata  <= d;
        do
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        do
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : rdr

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard, the run needs a few hundred cycles at most
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            wrap_up();
        end
    end

    initial
    begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdr(xprc_pkg::CTRL_OFF, rd, rsp);
        chk(rd, 32'h0);
        chk(32'(rsp), 32'(xprc_pkg::RESP_OKAY));
        rdr(8'h0c, rd, rsp);
        chk(rd, 32'h0);
        chk(32'(rsp), 32'(xprc_pkg::RESP_SLVERR));
        wr(8'h0c, 32'h1ff, rsp);
        chk(32'(rsp), 32'(xprc_pkg::RESP_SLVERR));
        $display("test registers done");
        // routing per latency mode, then pipe clock choice
        for (i = 0; i < 4; i++)
        begin
            // mode 2 needs both latency and feedback bits
            wr(xprc_pkg::CTRL_OFF, i == 3 ? 32'h80 : i == 2 ? 32'h60 : i * 32'h20, rsp);
            repeat (3) @(posedge clk);
            chk(32'({txRefSel, rxRefSel}), i == 1 ? 32'h000249 : i == 2 ? 32'h688fac : 32'h0);
            chk(32'({offsetCalClkSel, rxDetectClkSel}), i == 3 ? 32'h3 : 32'h0);
        end
        $display("test routing done");
        model.bring_up();
        rdr(xprc_pkg::STATUS_OFF, rd, rsp);
        chk(rd, 32'h1);
        wr(xprc_pkg::STATUS_OFF, 32'h3f, rsp);
        rdr(xprc_pkg::STATUS_OFF, rd, rsp);
        chk(rd, 32'h1);
        // software reset bits reach the coding resets
        wr(xprc_pkg::CTRL_OFF, 32'h1c, rsp);
        rdr(xprc_pkg::STATUS_OFF, rd, rsp);
        chk(rd, 32'h39);
        $display("test lock done");
        model.pulse(0, 1);
        model.pulse(1, 2);
        rdr(xprc_pkg::EVENT_OFF, rd, rsp);
        chk(rd, 32'h1);
        wr(xprc_pkg::EVENT_OFF, 32'h1, rsp);
        rdr(xprc_pkg::EVENT_OFF, rd, rsp);
        chk(rd, 32'h0);
        $display("test pulses done");
        wr(xprc_pkg::CTRL_OFF, 32'h100, rsp);
        repeat (3) @(posedge clk);
        fc = fabricClkOut;
        @(posedge clk);
        chk(32'(fc ^ fabricClkOut), 32'h1);
        model.drive(3, 1'b1);
        model.pulse(2, 2);
        repeat (2) @(posedge clk);
        chk(32'({pllHold, pllLock}), 32'h2);
        rdr(xprc_pkg::EVENT_OFF, rd, rsp);
        chk(rd, 32'h10);
        model.drive(4, 1'b1);
        repeat (3) @(posedge clk);
        chk(32'({pdCodingSublayer, pdHighSpeedSerialIf, pdClockDataRecovery, pdPcie, refClkBufEn}), 32'h1f);
        chk(32'(fabricClkOut), 32'h0);
        rdr(xprc_pkg::STATUS_OFF, rd, rsp);
        chk(rd, 32'h3e);
        $display("test hold and power-down done");
        wrap_up();
    end
endmodule : xprc_ctrl_test
